// file: hdl/isft_regs.svh
// Register offsets, field positions and timing counts of the frame timing block
`ifndef ISFT_REGS_SVH
`define ISFT_REGS_SVH
`define ISFT_OFF_GAIN      8'h00
`define ISFT_OFF_EXPO      8'h10
`define ISFT_OFF_CLKDIV    8'h11
`define ISFT_OFF_MODE      8'h12
`define ISFT_OFF_DPCTL     8'h2A
`define ISFT_OFF_DPLOW     8'h2B
`define ISFT_OFF_DLINES    8'h2D
`define ISFT_OFF_WCOLS     8'h17
`define ISFT_OFF_WROWS     8'h19
`define ISFT_OFF_RBGAIN    8'h01
`define ISFT_OFF_STATUS    8'h3F
`define ISFT_MODE_SRST     7
`define ISFT_MODE_RES      6
`define ISFT_MODE_SLAVE    5
`define ISFT_MODE_SINGLE   4
`define ISFT_MODE_SNAP     3
`define ISFT_MODE_BLC      2
`define ISFT_MODE_AWB      1
`define ISFT_DIV_LSB       0
`define ISFT_EXPO_MAX      8'hFF
`define ISFT_GAIN_2X       8'h10
`define ISFT_MAX_COLS      16'd1618
`define ISFT_MAX_ROWS      16'd1204
`define ISFT_WIN_COLS_RST  8'hC8
`define ISFT_WIN_ROWS_RST  8'h96
`define ISFT_MODE_RST      8'h04
`define ISFT_AWB_STEP      8'h01
`define ISFT_BLACK_RST     10'h040
// Host APB map
`define ISFT_APB_CMD       12'h000
`define ISFT_APB_DATA      12'h004
`define ISFT_APB_STAT      12'h008
`define ISFT_APB_PINS      12'h00C
`endif

// file: hdl/isft_pkg.sv
// Types shared by both ends of the frame timing link
`default_nettype none
package isft_pkg;
  typedef logic [7:0] isft_byte_t;
  typedef logic [9:0] isft_pix_t;
  typedef enum logic [5:0] {
    ISFT_LIVE   = 6'b000001,
    ISFT_PRECH  = 6'b000010,
    ISFT_HOLD   = 6'b000100,
    ISFT_EXPOSE = 6'b001000,
    ISFT_READ   = 6'b010000,
    ISFT_IDLE   = 6'b100000
  } isft_state_e;
endpackage
`default_nettype wire

// file: hdl/isft_if.sv
// Pins between camera host and image sensor timing block
`default_nettype none
interface isft_if;
  logic                   frame_exposure_enable;
  logic                   exposure_start_trigger;
  logic                   reg_req;
  logic                   reg_we;
  isft_pkg::isft_byte_t   reg_addr;
  isft_pkg::isft_byte_t   reg_wdata;
  isft_pkg::isft_byte_t   reg_rdata;
  logic                   reg_ack;
  logic                   vsync;
  logic                   href;
  logic                   pix_valid;
  isft_pkg::isft_pix_t    pix_data;
  modport sensor (input frame_exposure_enable, exposure_start_trigger, reg_req, reg_we,
                  reg_addr, reg_wdata, output reg_rdata, reg_ack, vsync, href,
                  pix_valid, pix_data);
  modport host   (output frame_exposure_enable, exposure_start_trigger, reg_req, reg_we,
                  reg_addr, reg_wdata, input reg_rdata, reg_ack, vsync, href,
                  pix_valid, pix_data);
endinterface
`default_nettype wire

// file: hdl/isft_sensor.sv
// Image sensor timing generator, exposure sequencer and register file
//
// Local design decision: the APB register port.
`include "isft_regs.svh"
`default_nettype none
module isft_sensor #(
  parameter int LINE_PIX   = 64,
  parameter int FRAME_ROWS = 16,
  parameter int VS_LINES   = 2
) (
  input  wire logic           pclk,
  input  wire logic           presetn,
  input  wire logic           clk_en,
  isft_if.sensor              link,
  input  wire isft_pkg::isft_pix_t adc_sample,
  input  wire logic           black_pixel,
  output logic                snapshot_mode,
  output logic                slave_mode,
  output logic                array_reset,
  output logic                exposing,
  input  wire logic           ext_vsync,
  input  wire logic           ext_href
);
  import isft_pkg::*;

  // Register file
  isft_byte_t gain_q, expo_q, clkdiv_q, mode_q, dpctl_q, dplow_q, dlines_q;
  isft_byte_t wcols_q, wrows_q, rbgain_q, rdata_q;
  logic       ack_q, res_prev_q, cnt_reset_q;
  // Values latched at frame boundary and on counter reset
  isft_byte_t div_f_q, dpx_f_q, dln_f_q;
  // Timing counters
  logic [7:0]  pre_q;
  logic [15:0] col_q, row_q;
  isft_state_e st_q, st_d;
  logic [9:0]  black_q;
  isft_pix_t   pix_q;
  logic        vs_q, hr_q, pv_q;

  // Pin synchronisers: three stages, change counted when two and three agree
  logic [2:0] fx_s, tr_s, ev_s, eh_s;
  logic       fx, tr, ev, eh;
  wire  fx_rise = fx_s[1] & fx_s[2] & ~fx;
  wire  fx_fall = ~fx_s[1] & ~fx_s[2] & fx;
  wire  tr_hi   = tr_s[1] & tr_s[2];
  wire  tr_lo   = ~tr; // Agreed trigger level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fx_s <= 3'h0; tr_s <= 3'h0; ev_s <= 3'h0; eh_s <= 3'h0;
      fx <= 1'b0; tr <= 1'b0; ev <= 1'b0; eh <= 1'b0;
    end else if (clk_en) begin
      fx_s <= {fx_s[1:0], link.frame_exposure_enable};
      tr_s <= {tr_s[1:0], link.exposure_start_trigger};
      ev_s <= {ev_s[1:0], ext_vsync};
      eh_s <= {eh_s[1:0], ext_href};
      if (fx_s[1] == fx_s[2]) fx <= fx_s[2];
      if (tr_s[1] == tr_s[2]) tr <= tr_s[2];
      if (ev_s[1] == ev_s[2]) ev <= ev_s[2];
      if (eh_s[1] == eh_s[2]) eh <= eh_s[2];
    end
  end

  // Register decode
  wire wr = link.reg_req & link.reg_we & ~ack_q;
  wire wr_mode = wr & (link.reg_addr == `ISFT_OFF_MODE);
  wire mode_chg = wr_mode & (link.reg_wdata != mode_q);
  // Counter reset: divider write or falling edge of resolution bit
  wire res_fall = wr_mode & res_prev_q & ~link.reg_wdata[`ISFT_MODE_RES];
  wire cnt_rst = res_fall | (wr & (link.reg_addr == `ISFT_OFF_CLKDIV));
  wire srst = wr_mode & link.reg_wdata[`ISFT_MODE_SRST];
  wire line_end = (col_q >= (16'(LINE_PIX) + 16'(dpx_f_q)) - 16'd1);
  wire frame_end = line_end &
                   (row_q >= (16'(FRAME_ROWS) + 16'(VS_LINES) + 16'(dln_f_q)) - 16'd1);
  logic [7:0] div_cnt_q;
  wire tick = (div_cnt_q >= div_f_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gain_q <= 8'h00; expo_q <= 8'h00; clkdiv_q <= 8'h00; mode_q <= `ISFT_MODE_RST;
      dpctl_q <= 8'h00; dplow_q <= 8'h00; dlines_q <= 8'h00;
      wcols_q <= `ISFT_WIN_COLS_RST; wrows_q <= `ISFT_WIN_ROWS_RST; rbgain_q <= 8'h80;
      ack_q <= 1'b0; rdata_q <= 8'h00; res_prev_q <= 1'b0; cnt_reset_q <= 1'b0;
    end else if (clk_en) begin
      ack_q <= link.reg_req & ~ack_q;
      cnt_reset_q <= cnt_rst;
      if (srst) begin
        gain_q <= 8'h00; expo_q <= 8'h00; clkdiv_q <= 8'h00; mode_q <= `ISFT_MODE_RST;
        dpctl_q <= 8'h00; dplow_q <= 8'h00; dlines_q <= 8'h00;
        wcols_q <= `ISFT_WIN_COLS_RST; wrows_q <= `ISFT_WIN_ROWS_RST;
      end else if (wr) begin
        unique case (link.reg_addr)
          `ISFT_OFF_GAIN:   gain_q <= link.reg_wdata;
          `ISFT_OFF_EXPO:   expo_q <= link.reg_wdata;
          `ISFT_OFF_CLKDIV: clkdiv_q <= link.reg_wdata;
          `ISFT_OFF_MODE: begin
            mode_q <= link.reg_wdata;
            res_prev_q <= link.reg_wdata[`ISFT_MODE_RES];
          end
          `ISFT_OFF_DPCTL:  dpctl_q <= link.reg_wdata;
          `ISFT_OFF_DPLOW:  dplow_q <= link.reg_wdata;
          `ISFT_OFF_DLINES: dlines_q <= link.reg_wdata;
          `ISFT_OFF_WCOLS:  wcols_q <= link.reg_wdata;
          `ISFT_OFF_WROWS:  wrows_q <= link.reg_wdata;
          `ISFT_OFF_RBGAIN: if (!mode_q[`ISFT_MODE_AWB]) rbgain_q <= link.reg_wdata;
          default: ;
        endcase
        if (mode_chg) begin
          wcols_q <= `ISFT_WIN_COLS_RST;
          wrows_q <= `ISFT_WIN_ROWS_RST;
        end
      end else if (mode_q[`ISFT_MODE_AWB] && pv_q && col_q[0]) begin
        // Auto balance nudges red/blue gain toward green level
        if (pix_q[9:8] > 2'h2) rbgain_q <= rbgain_q - `ISFT_AWB_STEP;
        else if (pix_q[9:8] < 2'h1) rbgain_q <= rbgain_q + `ISFT_AWB_STEP;
      end
      if (link.reg_req && !link.reg_we && !ack_q) begin
        unique case (link.reg_addr)
          `ISFT_OFF_GAIN:   rdata_q <= gain_q;
          `ISFT_OFF_EXPO:   rdata_q <= expo_q;
          `ISFT_OFF_CLKDIV: rdata_q <= clkdiv_q;
          `ISFT_OFF_MODE:   rdata_q <= mode_q;
          `ISFT_OFF_DPCTL:  rdata_q <= dpctl_q;
          `ISFT_OFF_DPLOW:  rdata_q <= dplow_q;
          `ISFT_OFF_DLINES: rdata_q <= dlines_q;
          `ISFT_OFF_WCOLS:  rdata_q <= wcols_q;
          `ISFT_OFF_WROWS:  rdata_q <= wrows_q;
          `ISFT_OFF_RBGAIN: rdata_q <= rbgain_q;
          `ISFT_OFF_STATUS: rdata_q <= {2'h0, st_q};
          default:          rdata_q <= 8'h00;
        endcase
      end
    end
  end

  // Exposure sequencer
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ISFT_LIVE, ISFT_IDLE:
        if (fx_rise) st_d = tr_hi ? ISFT_HOLD : ISFT_PRECH;
      ISFT_PRECH:  if (pre_q == 8'h00) st_d = ISFT_EXPOSE;
      ISFT_HOLD:   if (tr_lo && mode_q[`ISFT_MODE_SNAP]) st_d = ISFT_EXPOSE;
      ISFT_EXPOSE: if (fx_fall) st_d = ISFT_READ;
      ISFT_READ:   if (frame_end && tick)
                     st_d = mode_q[`ISFT_MODE_SINGLE] ? ISFT_IDLE : ISFT_LIVE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ISFT_LIVE; pre_q <= 8'h00; div_cnt_q <= 8'h00;
      col_q <= 16'h0; row_q <= 16'h0;
      div_f_q <= 8'h00; dpx_f_q <= 8'h00; dln_f_q <= 8'h00;
    end else if (clk_en) begin
      st_q <= st_d;
      pre_q <= (st_d == ISFT_PRECH && st_q != ISFT_PRECH) ? 8'(LINE_PIX - 1) :
               (pre_q != 8'h00 ? pre_q - 8'h01 : 8'h00);
      div_cnt_q <= (tick || cnt_reset_q) ? 8'h00 : div_cnt_q + 8'h01;
      if (cnt_reset_q) begin
        col_q <= 16'h0; row_q <= 16'h0;
        div_f_q <= clkdiv_q; dpx_f_q <= dplow_q; dln_f_q <= dlines_q;
      end else if (tick) begin
        if (line_end) begin
          col_q <= 16'h0;
          row_q <= frame_end ? 16'h0 : row_q + 16'h1;
        end else col_q <= col_q + 16'h1;
        if (frame_end) begin
          div_f_q <= clkdiv_q;
          dpx_f_q <= dplow_q;
          dln_f_q <= dlines_q;
        end
      end
    end
  end

  // Window limits and black level
  wire [15:0] win_c = (16'(wcols_q) << 3) > `ISFT_MAX_COLS ? `ISFT_MAX_COLS : (16'(wcols_q) << 3);
  wire [15:0] win_r = (16'(wrows_q) << 3) > `ISFT_MAX_ROWS ? `ISFT_MAX_ROWS : (16'(wrows_q) << 3);
  wire in_win = (col_q < win_c) & (col_q < 16'(LINE_PIX)) & (row_q < win_r) &
                (row_q < 16'(FRAME_ROWS));
  wire out_ok = (st_q == ISFT_LIVE) | (st_q == ISFT_READ);
  wire [10:0] diff = {1'b0, adc_sample} - {1'b0, black_q};
  wire isft_pix_t corr = diff[10] ? 10'h000 : diff[9:0];

  // Video port outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      black_q <= `ISFT_BLACK_RST; pix_q <= 10'h000;
      vs_q <= 1'b0; hr_q <= 1'b0; pv_q <= 1'b0;
    end else if (clk_en) begin
      if (tick && black_pixel) black_q <= 10'(({1'b0, black_q} + {1'b0, adc_sample}) >> 1);
      // Slave mode: pixels only inside the external line strobe
      pv_q  <= tick & in_win & out_ok & (~slave_mode | eh);
      pix_q <= mode_q[`ISFT_MODE_BLC] ? corr : adc_sample;
      vs_q  <= slave_mode ? ev : (row_q >= 16'(FRAME_ROWS));
      hr_q  <= slave_mode ? eh : (in_win & out_ok);
    end
  end

  assign slave_mode    = mode_q[`ISFT_MODE_SLAVE];
  assign snapshot_mode = mode_q[`ISFT_MODE_SNAP];
  assign array_reset   = (st_q == ISFT_PRECH) | (st_q == ISFT_HOLD);
  assign exposing      = (st_q == ISFT_EXPOSE);
  assign link.reg_ack   = ack_q;
  assign link.reg_rdata = rdata_q;
  assign link.vsync     = vs_q;
  assign link.href      = hr_q;
  assign link.pix_valid = pv_q;
  assign link.pix_data  = pix_q;
endmodule
`default_nettype wire

// file: hdl/isft_host.sv
// Camera host: APB slave that drives sensor pins and register access
`include "isft_regs.svh"
`default_nettype none
module isft_host (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  isft_if.host             link,
  output logic [31:0]      frame_pixels
);
  import isft_pkg::*;

  logic       fx_q, tr_q, req_q, we_q, done_q;
  isft_byte_t addr_q, wdata_q, rdata_q;
  logic [31:0] pixcnt_q;

  wire acc   = psel & penable;
  wire wr    = acc & pwrite;
  wire a_cmd = (paddr == `ISFT_APB_CMD);
  wire a_dat = (paddr == `ISFT_APB_DATA);
  wire a_st  = (paddr == `ISFT_APB_STAT);
  wire a_pin = (paddr == `ISFT_APB_PINS);
  wire ack_now = req_q & link.reg_ack;

  // Commands: bit 8 write, bits 7:0 register offset; are software order
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fx_q <= 1'b0; tr_q <= 1'b0; req_q <= 1'b0; we_q <= 1'b0; done_q <= 1'b0;
      addr_q <= 8'h00; wdata_q <= 8'h00; rdata_q <= 8'h00; pixcnt_q <= 32'h0;
    end else if (clk_en) begin
      if (wr && a_pin) begin
        fx_q <= pwdata[0];
        tr_q <= pwdata[1];
      end
      if (wr && a_dat) wdata_q <= pwdata[7:0];
      if (ack_now) begin
        req_q <= 1'b0;
        done_q <= 1'b1; // Set wins over clear below
        if (!we_q) rdata_q <= link.reg_rdata;
      end else if (wr && a_cmd && !req_q) begin
        req_q <= 1'b1; we_q <= pwdata[8]; addr_q <= pwdata[7:0]; done_q <= 1'b0;
      end
      if (link.vsync) pixcnt_q <= 32'h0;
      else if (link.pix_valid) pixcnt_q <= pixcnt_q + 32'h1;
    end
  end

  assign pready  = 1'b1;
  assign pslverr = acc & ~(a_cmd | a_dat | a_st | a_pin);
  assign prdata  = a_dat ? {24'h0, rdata_q} :
                   a_st  ? {29'h0, link.vsync, done_q, req_q} :
                   a_pin ? {30'h0, tr_q, fx_q} : 32'h0;
  assign frame_pixels = pixcnt_q;
  assign link.frame_exposure_enable  = fx_q;
  assign link.exposure_start_trigger = tr_q;
  assign link.reg_req   = req_q;
  assign link.reg_we    = we_q;
  assign link.reg_addr  = addr_q;
  assign link.reg_wdata = wdata_q;
endmodule
`default_nettype wire

// file: tb/isft_link_assertions.sv
// Handshake and video checks on the host-to-sensor link
`default_nettype none
module isft_link_assertions (
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 reg_req,
  input wire logic                 reg_we,
  input wire isft_pkg::isft_byte_t reg_addr,
  input wire isft_pkg::isft_byte_t reg_wdata,
  input wire logic                 reg_ack,
  input wire logic                 href,
  input wire logic                 pix_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  import isft_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Request pending, then request answered
  sequence req_wait; reg_req && !reg_ack; endsequence
  sequence req_taken; req_wait ##1 reg_ack; endsequence
  chk_ack_one_cycle: assert property (reg_ack |=> !reg_ack)
    else $error("ack longer than one cycle");
  chk_ack_after_req: assert property (reg_ack |-> $past(reg_req))
    else $error("ack without request");
  chk_ack_in_time: assert property ($rose(reg_req) |-> ##[1:4] reg_ack)
    else $error("ack late");
  chk_req_fields_held: assert property (req_wait |=>
      $stable(reg_addr) && $stable(reg_we) && $stable(reg_wdata))
    else $error("request fields moved");
  chk_req_held_on: assert property (req_wait |=> reg_req)
    else $error("request dropped early");
  chk_req_released: assert property (req_taken |=> !reg_req)
    else $error("request not released");
  chk_req_no_ack: assert property ($rose(reg_req) |-> !reg_ack)
    else $error("request during ack");
  chk_pix_in_line: assert property (pix_valid |-> href)
    else $error("pixel outside line");
endmodule
`default_nettype wire

// file: tb/tb.sv
// Bench: APB master driving the host end, joined to the sensor end
`include "isft_regs.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import isft_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic        pready, pslverr, e, black_pixel = 1'b0;
  isft_pix_t   adc_sample = 10'h000;
  logic        snapshot_mode, slave_mode, array_reset, exposing;
  int          errors = 0, tests_run = 0, n, p0, p1;
  logic [31:0] frame_pixels;
  logic        ext_sync = 1'b0;
  realtime     t0;
  isft_if bus ();
  // Clock and a moving sample source
  always #25 pclk = ~pclk;
  always @(posedge pclk) begin
    adc_sample  <= adc_sample + 10'h001;
    black_pixel <= adc_sample[3];
  end
  isft_host isft_host_i (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(bus.host), .frame_pixels(frame_pixels));
  isft_sensor isft_sensor_i (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .link(bus.sensor), .adc_sample(adc_sample), .black_pixel(black_pixel),
    .snapshot_mode(snapshot_mode), .slave_mode(slave_mode), .array_reset(array_reset),
    .exposing(exposing), .ext_vsync(ext_sync), .ext_href(ext_sync));
  isft_link_assertions isft_link_assertions_i (.pclk(pclk), .presetn(presetn),
    .reg_req(bus.reg_req), .reg_we(bus.reg_we), .reg_addr(bus.reg_addr),
    .reg_wdata(bus.reg_wdata), .reg_ack(bus.reg_ack), .href(bus.href),
    .pix_valid(bus.pix_valid));
  task automatic end_of_test;
    if (errors == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until pready is seen
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // Sensor register access through the host command window
  task automatic sacc(input logic we, input logic [7:0] off, input logic [7:0] wd);
    if (we)
      apb(1'b1, `ISFT_APB_DATA, {24'h0, wd});
    apb(1'b1, `ISFT_APB_CMD, {23'h0, we, off});
    do apb(1'b0, `ISFT_APB_STAT, 32'h0); while (r[1:0] !== 2'b10);
    apb(1'b0, `ISFT_APB_DATA, 32'h0);
  endtask
  // Cycles between two vsync rises
  task automatic frame_len(output int len);
    realtime t;
    @(posedge bus.vsync);
    t = $realtime;
    @(posedge bus.vsync);
    len = int'(($realtime - t) / 50.0);
  endtask
  // Exposure pass, readout and the state that follows
  task automatic expo(input logic trig, input isft_state_e fin);
    apb(1'b1, `ISFT_APB_PINS, {30'h0, trig, 1'b1});
    for (n = 0; n < 20 && array_reset !== 1'b1; n++) @(posedge pclk);
    if (trig) begin
      repeat (100) @(posedge pclk);
      chk({31'h0, array_reset}, 32'h1);
      chk({31'h0, exposing}, 32'h0);
      apb(1'b1, `ISFT_APB_PINS, 32'h1);
    end else begin
      for (n = 0; n < 200 && array_reset === 1'b1; n++) @(posedge pclk);
      chk(n, 64);
    end
    for (n = 0; n < 300 && exposing !== 1'b1; n++) @(posedge pclk);
    chk({31'h0, exposing}, 32'h1);
    apb(1'b1, `ISFT_APB_PINS, 32'h0);
    for (n = 0; n < 3000 && bus.pix_valid !== 1'b1; n++) @(posedge pclk);
    chk({31'h0, bus.pix_valid}, 32'h1);
    for (n = 0; n < 400; n++) begin
      sacc(1'b0, `ISFT_OFF_STATUS, 8'h00);
      if (r[5:0] === ISFT_LIVE || r[5:0] === ISFT_IDLE)
        break;
    end
    chk({26'h0, r[5:0]}, {26'h0, fin});
  endtask
  // Watchdog
  initial begin
    #3000000;
    errors++;
    end_of_test();
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    sacc(1'b0, `ISFT_OFF_MODE, 8'h00);
    chk(r, {24'h0, `ISFT_MODE_RST});
    chk({30'h0, slave_mode, snapshot_mode}, 32'h0);
    sacc(1'b1, `ISFT_OFF_EXPO, `ISFT_EXPO_MAX);
    sacc(1'b1, `ISFT_OFF_GAIN, `ISFT_GAIN_2X);
    sacc(1'b0, `ISFT_OFF_GAIN, 8'h00);
    chk(r, {24'h0, `ISFT_GAIN_2X});
    sacc(1'b1, `ISFT_OFF_WCOLS, 8'h10);
    sacc(1'b1, `ISFT_OFF_MODE, 8'h0C);
    sacc(1'b0, `ISFT_OFF_WCOLS, 8'h00);
    chk(r, {24'h0, `ISFT_WIN_COLS_RST});
    chk({31'h0, snapshot_mode}, 32'h1);
    frame_len(p0);
    frame_len(p0);
    chk(p0, 64 * 18);
    // Pixels of one frame: 64 columns by 16 rows
    @(posedge bus.vsync);
    @(posedge pclk);
    chk(frame_pixels, 32'h400);
    sacc(1'b1, `ISFT_OFF_CLKDIV, 8'h01);
    frame_len(p1);
    frame_len(p1);
    chk(p1, 2 * p0);
    sacc(1'b1, `ISFT_OFF_DPLOW, 8'h08);
    sacc(1'b1, `ISFT_OFF_CLKDIV, 8'h00);
    // Counter restart: 16 lines of 72 to vsync, less task tail
    t0 = $realtime;
    @(posedge bus.vsync);
    chk(int'(($realtime - t0) / 50.0), (64 + 8) * 16 - 3);
    frame_len(p1);
    frame_len(p1);
    chk({31'h0, p1 > p0}, 32'h1);
    sacc(1'b1, `ISFT_OFF_DPLOW, 8'h00);
    sacc(1'b1, `ISFT_OFF_DLINES, 8'h02);
    frame_len(p1);
    frame_len(p1);
    chk({31'h0, p1 > p0}, 32'h1);
    sacc(1'b1, `ISFT_OFF_DLINES, 8'h00);
    // Resolution bit pulse restarts the counters
    sacc(1'b1, `ISFT_OFF_MODE, 8'h4C);
    sacc(1'b1, `ISFT_OFF_MODE, 8'h0C);
    t0 = $realtime;
    @(posedge bus.vsync);
    chk(int'(($realtime - t0) / 50.0), 64 * 16 - 3);
    sacc(1'b1, `ISFT_OFF_WCOLS, 8'h10);
    sacc(1'b0, `ISFT_OFF_WCOLS, 8'h00);
    chk(r, 32'h10);
    sacc(1'b1, `ISFT_OFF_MODE, 8'h2C);
    chk({31'h0, slave_mode}, 32'h1);
    // Slave port follows external syncs
    ext_sync <= 1'b1;
    repeat (8) @(posedge pclk);
    chk({30'h0, bus.vsync, bus.href}, 32'h3);
    ext_sync <= 1'b0;
    sacc(1'b1, `ISFT_OFF_MODE, 8'h0C);
    apb(1'b0, 12'h010, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
    expo(1'b1, ISFT_LIVE);
    sacc(1'b1, `ISFT_OFF_MODE, 8'h1C);
    expo(1'b0, ISFT_IDLE);
    // Correction off: pixel is last cycle's raw sample
    sacc(1'b1, `ISFT_OFF_MODE, 8'h08);
    @(posedge pclk);
    chk({22'h0, bus.pix_data}, {22'h0, adc_sample - 10'h001});
    end_of_test();
  end
endmodule
`default_nettype wire
